// ### bpcu_pkg.sv
package bpcu_pkg;

    // ****************************************
    // address window
    // ****************************************
    localparam logic [15:0] BP_LO_END     = 16'h01ff;
    localparam logic [15:0] BP_HI_START   = 16'h8000;
    localparam logic [15:0] BP_HI_END     = 16'h800f;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [15:0] CMD_RESET     = 16'h00f0;
    localparam logic [15:0] CMD_LOAD      = 16'h00e0;
    localparam logic [15:0] CMD_LOAD_2ND  = 16'h0000;
    localparam logic [15:0] CMD_IDENT     = 16'h0090;

    // ****************************************
    // identification addresses and values
    // ****************************************
    localparam logic [15:0] ID_ADDR_MAKER = 16'h0000;
    localparam logic [15:0] ID_ADDR_DEV   = 16'h0001;
    localparam logic [15:0] ID_ADDR_WP    = 16'h0002;
    // arbitrary identity values
    localparam logic [15:0] MAKER_CODE    = 16'h00a5;
    localparam logic [15:0] DEVICE_CODE   = 16'h0042;

    // ****************************************
    // address fields and reset values
    // ****************************************
    localparam int          FBA_W         = 10;
    localparam int          FPA_W         = 6;
    localparam int          BOOT_AW       = 9;
    localparam logic [9:0]  FBA_RST       = 10'h000;
    localparam logic [5:0]  FPA_RST       = 6'h00;
    localparam logic [5:0]  FPA_STEP      = 6'h01;
    localparam logic [15:0] ECC_RST       = 16'h0000;
    localparam logic [2:0]  WP_RST        = 3'h2;

    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_LOAD2 = 4'b0010,
        ST_IDENT = 4'b0100,
        ST_BUSY  = 4'b1000
    } bpcu_state_type;

    typedef enum logic [4:0] {
        BUS_STANDBY = 5'b00001,
        BUS_WRITE   = 5'b00010,
        BUS_READ    = 5'b00100,
        BUS_BLOAD   = 5'b01000,
        BUS_BURST   = 5'b10000
    } bpcu_bus_type;

    typedef struct packed {
        logic        cs_n;
        logic        oe_n;
        logic        we_n;
        logic        address_valid_n;
        logic        warm_reset_n;
        logic [15:0] addr;
        logic [15:0] data;
    } bpcu_host_type;

    typedef struct packed {
        logic [15:0] data;
        logic        data_oe_n;
    } bpcu_dq_type;

endpackage

// ### bpcu_boot_mem.sv
`timescale 1ns/1ps
module bpcu_boot_mem
    import bpcu_pkg::*;
(
    input  wire logic               core_clk_in,
    input  wire logic               wr_en_in,
    input  wire logic [BOOT_AW-1:0] wr_addr_in,
    input  wire logic [15:0]        wr_data_in,
    input  wire logic [BOOT_AW-1:0] rd_addr_in,
    output logic      [15:0]        rd_data_out
);
    logic [15:0] mem [0:(1<<BOOT_AW)-1];

    // no reset: contents come from the boot loader port
    always_ff @(posedge core_clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        rd_data_out <= mem[rd_addr_in];
    end
endmodule

// ### bpcu_top.sv
`timescale 1ns/1ps
// Functional notes
// - commands only recognised at 0000h..01FFh or 8000h..800Fh
// - boot area reads return boot buffer only when no command pending
// - writes outside the window pass on as ordinary buffer or register writes
// - a command starts only after its last cycle arrives
// - wrong data or unknown command aborts sequence to ready; a write outside the window leaves a load sequence pending
// - write of 00F0h in ready state resets state, pending flag, block, page and ECC registers to defaults
// - 00E0h then 0000h loads one 2KB page into the first data buffer
// - page load uses block and page address only, ignores sector fields
// - page address increments by one after each page load
// - page increment wraps inside the block, never carries into block address
// - block and page address default to zero
// - 0090h then a read: 0000h maker, 0001h device, 0002h protection status
// - a write strobe toggle ends an identification read
// - command operations use asynchronous cycles only, never burst
// - burst address latch with chip select low, strobes high, dq undriven
// - chip select toggle with new address restarts burst, dq undriven
// - any command clears the ECC status register
module bpcu_top
    import bpcu_pkg::*;
(
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_in,
    input  wire bpcu_host_type        host_in,
    input  wire logic [FBA_W-1:0]     fba_wr_data_in,
    input  wire logic                 fba_wr_in,
    input  wire logic [2:0]           wp_status_in,
    input  wire logic                 page_load_done_in,
    input  wire logic                 ecc_update_in,
    input  wire logic [15:0]          ecc_status_in,
    input  wire logic                 boot_fill_in,
    input  wire logic [BOOT_AW-1:0]   boot_fill_addr_in,
    input  wire logic [15:0]          boot_fill_data_in,
    input  wire logic [15:0]          buffer_rd_data_in,
    output bpcu_dq_type               dq_out,
    output logic                      buffer_wr_out,
    output logic [15:0]               buffer_wr_addr_out,
    output logic [15:0]               buffer_wr_data_out,
    output logic                      page_load_req_out,
    output logic [FBA_W-1:0]          flash_block_addr_out,
    output logic [FPA_W-1:0]          flash_page_addr_out,
    output logic [15:0]               ecc_status_out,
    output logic                      busy_out,
    output logic                      cmd_pending_out,
    output logic                      burst_start_out,
    output logic [15:0]               burst_addr_out,
    output bpcu_bus_type              bus_op_out
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic in_window(input logic [15:0] a);
        in_window = (a <= BP_LO_END) || ((a >= BP_HI_START) && (a <= BP_HI_END));
    endfunction

    function automatic bpcu_bus_type decode_bus(input bpcu_host_type h);
        if (h.cs_n) begin
            decode_bus = BUS_STANDBY;
        end else if (!h.we_n && h.oe_n) begin
            decode_bus = BUS_WRITE;
        end else if (!h.oe_n && h.we_n) begin
            decode_bus = h.address_valid_n ? BUS_READ : BUS_BURST;
        end else if (h.oe_n && h.we_n && !h.address_valid_n) begin
            decode_bus = BUS_BLOAD;
        end else begin
            decode_bus = BUS_STANDBY;
        end
    endfunction

    // ****************************************
    // strobe edges
    // ****************************************
    bpcu_host_type  host_prev_r;
    bpcu_bus_type   bus_now;
    logic           wr_edge;
    logic           rd_edge;
    logic           cs_fall;
    logic           win_wr;
    logic           win_rd;
    logic           warm_rst;
    logic           soft_rst;

    assign bus_now  = decode_bus(host_in);
    assign warm_rst = !host_in.warm_reset_n;
    assign wr_edge  = host_prev_r.we_n && !host_in.we_n && !host_in.cs_n && host_in.oe_n;
    assign rd_edge  = host_prev_r.oe_n && !host_in.oe_n && !host_in.cs_n && host_in.we_n
                      && host_in.address_valid_n;
    assign cs_fall  = host_prev_r.cs_n && !host_in.cs_n;
    assign win_wr   = wr_edge && in_window(host_in.addr);
    assign win_rd   = rd_edge && in_window(host_in.addr);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            host_prev_r <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, address_valid_n: 1'b1,
                             warm_reset_n: 1'b1, addr: 16'h0000, data: 16'h0000};
        end else begin
            host_prev_r <= host_in;
        end
    end

    // ****************************************
    // command state machine
    // ****************************************
    bpcu_state_type state_r;
    bpcu_state_type state_nxt;
    logic           cmd_pending_r;
    logic           load_go;
    logic           ident_go;
    logic           any_cmd;

    assign soft_rst = win_wr && (state_r == ST_READY) && (host_in.data == CMD_RESET);

    always_comb begin
        state_nxt = state_r;
        load_go   = 1'b0;
        ident_go  = 1'b0;
        case (state_r)
            ST_READY: begin
                if (win_wr) begin
                    if (host_in.data == CMD_LOAD) begin
                        state_nxt = ST_LOAD2;
                    end else if (host_in.data == CMD_IDENT) begin
                        state_nxt = ST_IDENT;
                        ident_go  = 1'b1;
                    end
                end
            end
            ST_LOAD2: begin
                if (win_wr) begin
                    if (host_in.data == CMD_LOAD_2ND) begin
                        state_nxt = ST_BUSY;
                        load_go   = 1'b1;
                    end else begin
                        state_nxt = ST_READY;
                    end
                end
            end
            ST_IDENT: begin
                if (win_rd || wr_edge) begin
                    state_nxt = ST_READY;
                end
            end
            ST_BUSY: begin
                if (page_load_done_in) begin
                    state_nxt = ST_READY;
                end
            end
            default: state_nxt = ST_READY;
        endcase
    end

    assign any_cmd = soft_rst || load_go || ident_go;

    always_ff @(posedge core_clk_in) begin
        if (rst_in || warm_rst || soft_rst) begin
            state_r <= ST_READY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // pending flag gates boot buffer reads
    always_ff @(posedge core_clk_in) begin
        if (rst_in || warm_rst || soft_rst) begin
            cmd_pending_r <= 1'b0;
        end else if (win_wr && (state_r == ST_READY) && (host_in.data == CMD_LOAD
                     || host_in.data == CMD_IDENT)) begin
            cmd_pending_r <= 1'b1;
        end else if (state_nxt == ST_READY && state_r != ST_READY) begin
            cmd_pending_r <= 1'b0;
        end
    end

    // ****************************************
    // flash address registers
    // ****************************************
    logic [FBA_W-1:0] fba_r;
    logic [FPA_W-1:0] fpa_r;

    always_ff @(posedge core_clk_in) begin
        if (rst_in || warm_rst || soft_rst) begin
            fba_r <= FBA_RST;
        end else if (fba_wr_in) begin
            fba_r <= fba_wr_data_in;
        end
    end

    // width of page field wraps naturally inside the block
    always_ff @(posedge core_clk_in) begin
        if (rst_in || warm_rst || soft_rst) begin
            fpa_r <= FPA_RST;
        end else if (state_r == ST_BUSY && page_load_done_in) begin
            fpa_r <= fpa_r + FPA_STEP;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            page_load_req_out    <= 1'b0;
            flash_block_addr_out <= FBA_RST;
            flash_page_addr_out  <= FPA_RST;
        end else begin
            page_load_req_out    <= load_go;
            flash_block_addr_out <= fba_r;
            flash_page_addr_out  <= fpa_r;
        end
    end

    // ****************************************
    // ecc status
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        if (rst_in || warm_rst || any_cmd) begin
            ecc_status_out <= ECC_RST;
        end else if (ecc_update_in) begin
            ecc_status_out <= ecc_status_in;
        end
    end

    // ****************************************
    // buffer writes outside the window
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            buffer_wr_out      <= 1'b0;
            buffer_wr_addr_out <= 16'h0000;
            buffer_wr_data_out <= 16'h0000;
        end else begin
            buffer_wr_out      <= wr_edge && !in_window(host_in.addr);
            buffer_wr_addr_out <= host_in.addr;
            buffer_wr_data_out <= host_in.data;
        end
    end

    // ****************************************
    // read data path
    // ****************************************
    logic [15:0]  boot_rd_data;
    logic [15:0]  id_word;
    logic         ident_rd_r;
    logic [15:0]  id_word_r;
    logic         win_rd_r;

    bpcu_boot_mem u_boot_mem (
        .core_clk_in (core_clk_in),
        .wr_en_in    (boot_fill_in),
        .wr_addr_in  (boot_fill_addr_in),
        .wr_data_in  (boot_fill_data_in),
        .rd_addr_in  (host_in.addr[BOOT_AW-1:0]),
        .rd_data_out (boot_rd_data)
    );

    always_comb begin
        case (host_in.addr)
            ID_ADDR_MAKER: id_word = MAKER_CODE;
            ID_ADDR_DEV:   id_word = DEVICE_CODE;
            ID_ADDR_WP:    id_word = {13'h0000, wp_status_in};
            default:       id_word = 16'h0000;
        endcase
    end

    // boot and id read data is valid two clocks after the output enable edge
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ident_rd_r <= 1'b0;
            id_word_r  <= 16'h0000;
            win_rd_r   <= 1'b0;
        end else begin
            ident_rd_r <= win_rd && (state_r == ST_IDENT) && !wr_edge;
            id_word_r  <= id_word;
            win_rd_r   <= win_rd && !cmd_pending_r;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in || warm_rst) begin
            dq_out <= '{data: 16'h0000, data_oe_n: 1'b1};
        end else if (host_in.oe_n || host_in.cs_n || !host_in.address_valid_n) begin
            dq_out <= '{data: 16'h0000, data_oe_n: 1'b1};
        end else if (ident_rd_r) begin
            dq_out <= '{data: id_word_r, data_oe_n: 1'b0};
        end else if (win_rd_r) begin
            dq_out <= '{data: boot_rd_data, data_oe_n: 1'b0};
        end else if (!in_window(host_in.addr) || cmd_pending_r) begin
            // boot and id words hold until oe rises
            dq_out <= '{data: buffer_rd_data_in, data_oe_n: 1'b0};
        end
    end

    // ****************************************
    // bus operation and burst latch
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            burst_start_out <= 1'b0;
            burst_addr_out  <= 16'h0000;
            bus_op_out      <= BUS_STANDBY;
        end else begin
            burst_start_out <= (bus_now == BUS_BLOAD) && (cs_fall
                               || host_prev_r.address_valid_n);
            if (bus_now == BUS_BLOAD) begin
                burst_addr_out <= host_in.addr;
            end
            bus_op_out      <= warm_rst ? BUS_STANDBY : bus_now;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            busy_out        <= 1'b0;
            cmd_pending_out <= 1'b0;
        end else begin
            busy_out        <= (state_r == ST_BUSY);
            cmd_pending_out <= cmd_pending_r;
        end
    end

endmodule

// ### bpcu_host_model.sv
`timescale 1ns/1ps
module bpcu_host_model
    import bpcu_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        page_load_req_in,
    input  wire bpcu_dq_type dq_in,
    output bpcu_host_type    host_out,
    output logic             fba_wr_out,
    output logic [FBA_W-1:0] fba_data_out,
    output logic             load_done_out
);
    // ****
    // host bus side
    // ****
    int load_lat = 3;
    int cnt = 0;
    initial begin
        host_out = '1;
        fba_wr_out = 1'b0;
        fba_data_out = '0;
        load_done_out = 1'b0;
    end
    // flash core answers a load after a fixed delay
    always @(posedge core_clk_in) begin
        load_done_out <= !page_load_req_in && cnt == 1;
        if (page_load_req_in) begin
            cnt <= load_lat;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // asynchronous cycles only; idle edges keep writes apart
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        host_out.cs_n <= 1'b0;
        host_out.addr <= a;
        host_out.data <= d;
        @(posedge core_clk_in);
        host_out.we_n <= 1'b0;
        @(posedge core_clk_in);
        host_out.we_n <= 1'b1;
        host_out.cs_n <= 1'b1;
        @(posedge core_clk_in);
        host_out.data <= ~d;
        repeat (2) @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [15:0] a, output bpcu_dq_type q);
        @(posedge core_clk_in);
        host_out.cs_n <= 1'b0;
        host_out.addr <= a;
        @(posedge core_clk_in);
        host_out.oe_n <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        q = dq_in;
        host_out.oe_n <= 1'b1;
        host_out.cs_n <= 1'b1;
        repeat (2) @(posedge core_clk_in);
    endtask
    task automatic burst(input logic [15:0] a);
        @(posedge core_clk_in);
        host_out.cs_n <= 1'b0;
        host_out.addr <= a;
        host_out.address_valid_n <= 1'b0;
        @(posedge core_clk_in);
        host_out.address_valid_n <= 1'b1;
        @(posedge core_clk_in);
        host_out.cs_n <= 1'b1;
        repeat (2) @(posedge core_clk_in);
    endtask
    task automatic warm();
        @(posedge core_clk_in);
        host_out.warm_reset_n <= 1'b0;
        @(posedge core_clk_in);
        host_out.warm_reset_n <= 1'b1;
        repeat (2) @(posedge core_clk_in);
    endtask
    task automatic set_block(input logic [FBA_W-1:0] b);
        @(posedge core_clk_in);
        fba_wr_out <= 1'b1;
        fba_data_out <= b;
        @(posedge core_clk_in);
        fba_wr_out <= 1'b0;
    endtask
endmodule

// ### bpcu_checker_sva.sv
`timescale 1ns/1ps
module bpcu_checker
    import bpcu_pkg::*;
(
    input wire logic             core_clk_in,
    input wire logic             rst_in,
    input wire bpcu_host_type    host_in,
    input wire logic             fba_wr_in,
    input wire logic             page_load_done_in,
    input wire logic             ecc_update_in,
    input wire bpcu_dq_type      dq_out,
    input wire logic             buffer_wr_out,
    input wire logic [15:0]      buffer_wr_addr_out,
    input wire logic [15:0]      buffer_wr_data_out,
    input wire logic             page_load_req_out,
    input wire logic [FBA_W-1:0] flash_block_addr_out,
    input wire logic [FPA_W-1:0] flash_page_addr_out,
    input wire logic [15:0]      ecc_status_out,
    input wire logic             busy_out,
    input wire logic             cmd_pending_out
);
    // ****
    // helpers
    // ****
    logic we_q;
    logic wr_edge;
    logic in_win;
    logic load2_hit;
    // strobe history starts high, as after reset
    always_ff @(posedge core_clk_in) begin
        we_q <= rst_in ? 1'b1 : host_in.we_n;
    end
    assign wr_edge = we_q && !host_in.we_n && !host_in.cs_n && host_in.oe_n
                     && host_in.warm_reset_n;
    assign in_win = (host_in.addr <= BP_LO_END) ||
                    (host_in.addr >= BP_HI_START && host_in.addr <= BP_HI_END);
    assign load2_hit = wr_edge && in_win && host_in.data == CMD_LOAD_2ND;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    chk_win_no_wr: assert property (wr_edge && in_win |=> !buffer_wr_out)
        else $error("window write reached buffer");
    chk_out_wr: assert property (wr_edge && !in_win && !busy_out |=> buffer_wr_out &&
        buffer_wr_addr_out == $past(host_in.addr) && buffer_wr_data_out == $past(host_in.data))
        else $error("ordinary write lost");
    chk_load_cause: assert property (page_load_req_out |-> $past(load2_hit))
        else $error("load without final cycle");
    chk_load_busy: assert property (page_load_req_out |=> busy_out)
        else $error("load not busy");
    chk_ecc_clear: assert property (page_load_req_out && !ecc_update_in |=>
        ecc_status_out == ECC_RST)
        else $error("ecc not cleared");
    chk_page_step: assert property (page_load_done_in && busy_out && !fba_wr_in |->
        ##2 flash_page_addr_out == $past(flash_page_addr_out, 2) + FPA_STEP &&
        flash_block_addr_out == $past(flash_block_addr_out, 2))
        else $error("page step wrong");
    chk_dq_idle: assert property (host_in.oe_n [*2] |-> dq_out.data_oe_n)
        else $error("dq driven while oe high");
    chk_reset_cmd: assert property (wr_edge && in_win && host_in.data == CMD_RESET &&
        !busy_out && !cmd_pending_out && !fba_wr_in |-> ##3 flash_page_addr_out == FPA_RST &&
        flash_block_addr_out == FBA_RST && ecc_status_out == ECC_RST)
        else $error("reset command ignored");
    cov_load: cover property (page_load_req_out);
    cov_read: cover property (!dq_out.data_oe_n);
    cov_done: cover property (page_load_done_in && busy_out);
endmodule
bind bpcu_top bpcu_checker CHK (.core_clk_in, .rst_in, .host_in, .fba_wr_in, .page_load_done_in,
    .ecc_update_in, .dq_out, .buffer_wr_out, .buffer_wr_addr_out, .buffer_wr_data_out,
    .page_load_req_out, .flash_block_addr_out, .flash_page_addr_out, .ecc_status_out,
    .busy_out, .cmd_pending_out);

// ### bpcu_top_tb.sv
`timescale 1ns/1ps
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module bpcu_top_tb;
    import bpcu_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    bpcu_host_type host_in;
    bpcu_dq_type dq_out;
    bpcu_bus_type bus_op_out;
    logic fba_wr_in, page_load_done_in, buffer_wr_out, page_load_req_out, busy_out;
    logic cmd_pending_out, burst_start_out;
    logic ecc_update_in = 1'b0;
    logic boot_fill_in = 1'b0;
    logic [FBA_W-1:0] fba_wr_data_in, flash_block_addr_out;
    logic [FPA_W-1:0] flash_page_addr_out;
    logic [BOOT_AW-1:0] boot_fill_addr_in = '0;
    logic [15:0] ecc_status_in = '0, boot_fill_data_in = '0;
    logic [15:0] buffer_rd_data_in;
    logic [2:0] wp_status_in;
    bpcu_bus_type last_op;
    logic [15:0] buffer_wr_addr_out, buffer_wr_data_out, ecc_status_out, burst_addr_out;
    logic [15:0] last_wa, last_wd, last_ba;
    int fail_count = 0, num_checks = 0, wr_cnt = 0, ld_cnt = 0, bs_cnt = 0, cyc = 0;
    bpcu_dq_type q;
    int n;
    always #10 core_clk_in = ~core_clk_in;
    bpcu_top DUT (.core_clk_in, .rst_in, .host_in, .fba_wr_data_in, .fba_wr_in,
        .wp_status_in, .page_load_done_in, .ecc_update_in, .ecc_status_in, .boot_fill_in,
        .boot_fill_addr_in, .boot_fill_data_in, .buffer_rd_data_in, .dq_out,
        .buffer_wr_out, .buffer_wr_addr_out, .buffer_wr_data_out, .page_load_req_out,
        .flash_block_addr_out, .flash_page_addr_out, .ecc_status_out, .busy_out,
        .cmd_pending_out, .burst_start_out, .burst_addr_out, .bus_op_out);
    bpcu_host_model HOST (.core_clk_in, .page_load_req_in(page_load_req_out), .dq_in(dq_out),
        .host_out(host_in), .fba_wr_out(fba_wr_in), .fba_data_out(fba_wr_data_in),
        .load_done_out(page_load_done_in));
    // ****
    // monitors and hang limit
    // ****
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (bus_op_out !== BUS_STANDBY) last_op <= bus_op_out;
        if (buffer_wr_out === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_wa <= buffer_wr_addr_out;
            last_wd <= buffer_wr_data_out;
        end
        if (page_load_req_out === 1'b1) ld_cnt <= ld_cnt + 1;
        if (burst_start_out === 1'b1) begin
            bs_cnt <= bs_cnt + 1;
            last_ba <= burst_addr_out;
        end
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        repeat (3) @(posedge core_clk_in);
        while (busy_out !== 1'b0 && k < 100) begin
            @(posedge core_clk_in);
            k++;
        end
        `CK(busy_out, 1'b0)
        repeat (3) @(posedge core_clk_in);
    endtask
    task automatic do_load(input logic [15:0] a);
        HOST.wr(a, CMD_LOAD);
        HOST.wr(a, CMD_LOAD_2ND);
        wait_idle();
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_boot();
        boot_fill_in <= 1'b1;
        boot_fill_addr_in <= 9'h005;
        boot_fill_data_in <= 16'h1234;
        @(posedge core_clk_in);
        boot_fill_in <= 1'b0;
        `CK(flash_page_addr_out, FPA_RST)
        `CK(flash_block_addr_out, FBA_RST)
        HOST.rd(16'h8005, q);
        `CK(q.data, 16'h1234)
        `CK(q.data_oe_n, 1'b0)
        $display("boot read done");
    endtask
    task automatic t_ordinary();
        n = wr_cnt;
        HOST.wr(16'h0200, 16'h5a5a);
        `CK(wr_cnt, n + 1)
        `CK(last_wa, 16'h0200)
        `CK(last_wd, 16'h5a5a)
        HOST.wr(16'h800f, 16'h0077);
        HOST.wr(16'h8010, 16'h0088);
        `CK(wr_cnt, n + 2)
        `CK(last_wa, 16'h8010)
        `CK(last_op, BUS_WRITE)
        buffer_rd_data_in <= 16'hc3a5;
        HOST.rd(16'h0200, q);
        `CK(q.data, 16'hc3a5)
        `CK(last_op, BUS_READ)
        $display("ordinary writes done");
    endtask
    task automatic t_load();
        n = ld_cnt;
        HOST.set_block(10'h003);
        ecc_update_in <= 1'b1;
        ecc_status_in <= 16'h00ff;
        @(posedge core_clk_in);
        ecc_update_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        `CK(ecc_status_out, 16'h00ff)
        HOST.wr(16'h8000, CMD_LOAD);
        `CK(ld_cnt, n)
        HOST.wr(16'h800f, CMD_LOAD_2ND);
        `CK(ld_cnt, n + 1)
        wait_idle();
        `CK(ecc_status_out, ECC_RST)
        `CK(flash_page_addr_out, 6'h01)
        `CK(flash_block_addr_out, 10'h003)
        $display("page load done");
    endtask
    task automatic t_abort();
        n = ld_cnt;
        HOST.wr(16'h0010, CMD_LOAD);
        HOST.wr(16'h0010, 16'h1234);
        `CK(ld_cnt, n)
        `CK(cmd_pending_out, 1'b0)
        HOST.rd(16'h0005, q);
        `CK(q.data, 16'h1234)
        $display("abort done");
    endtask
    task automatic t_reset_wrap();
        HOST.wr(16'h01ff, CMD_RESET);
        repeat (2) @(posedge core_clk_in);
        `CK(flash_page_addr_out, FPA_RST)
        `CK(flash_block_addr_out, FBA_RST)
        HOST.set_block(10'h3ff);
        HOST.load_lat = 9;
        repeat (63) do_load(16'h0123);
        `CK(flash_page_addr_out, 6'h3f)
        do_load(16'h8008);
        `CK(flash_page_addr_out, 6'h00)
        `CK(flash_block_addr_out, 10'h3ff)
        HOST.warm();
        `CK(flash_block_addr_out, FBA_RST)
        $display("reset and wrap done");
    endtask
    task automatic t_ident();
        logic [15:0] exp [3];
        exp = '{MAKER_CODE, DEVICE_CODE, 16'h0004};
        HOST.set_block(10'h002);
        wp_status_in <= 3'h4;
        for (int i = 0; i < 3; i++) begin
            HOST.wr(16'h0100, CMD_IDENT);
            HOST.rd(16'(i), q);
            `CK(q.data, exp[i])
        end
        wp_status_in <= 3'h1;
        HOST.wr(16'h0100, CMD_IDENT);
        HOST.rd(16'h0002, q);
        `CK(q.data, 16'h0001)
        HOST.wr(16'h0100, CMD_IDENT);
        HOST.wr(16'h0400, 16'h0000);
        HOST.rd(16'h0005, q);
        `CK(q.data, 16'h1234)
        $display("ident done");
    endtask
    task automatic t_burst();
        n = bs_cnt;
        HOST.burst(16'h1230);
        `CK(bs_cnt, n + 1)
        `CK(last_ba, 16'h1230)
        `CK(last_op, BUS_BLOAD)
        `CK(dq_out.data_oe_n, 1'b1)
        HOST.burst(16'h4560);
        `CK(bs_cnt, n + 2)
        `CK(last_ba, 16'h4560)
        $display("burst done");
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        t_boot();
        t_ordinary();
        t_load();
        t_abort();
        t_reset_wrap();
        t_ident();
        t_burst();
        conclude();
    end
endmodule
